// ---- include/pma_pkg.sv ----
// Purpose: constants and types shared by the port-mode arbiter
// Assumes: one clock i_mclk at 100 MHz, asynchronous active-high reset
// Notes: host commands arrive as one-cycle strobes with a code
// How it works
// - host mode ignores input and output port accesses
// - reset pin, soft reset, host commands enter host
// - control register writes host only, reads in every mode except the id and config submodes
// - table window registers accessed only in host; the window op also in config submode
// - table commands execute only in host mode
// - intermediate compare read only in host mode
// - id submode admits only its four operations and soft reset
// - config submode admits only its config operations and soft reset
// - standby command moves host to standby
// - standby write strobe starts input sequence
// - each write strobe steps input pointer once
// - input end halts pointer, back to standby
// - sequence reset reinitialises the stopped pointer
// - standby read strobe starts output sequence
// - read strobes step output pointer, halt at end
// - standby rejects host-only; host commands return
// - input mode rejects output and host-only operations
// - output mode rejects input and host-only operations
// - host interrupt commands switch at defined timing
// - select pin high keeps only submode limits
// - busy pins encode mode as tabled
// - sequence reset in a sequence returns standby
package pma_pkg;
  // ==========================================
  // host operation codes
  localparam logic [4:0] OP_NONE = 5'h00;
  localparam logic [4:0] OP_SOFT_RESET = 5'h01;
  localparam logic [4:0] OP_TO_HOST = 5'h02;
  localparam logic [4:0] OP_TO_HOST_IMM = 5'h03;
  localparam logic [4:0] OP_TO_HOST_SEQ_END = 5'h04;
  localparam logic [4:0] OP_TO_STANDBY = 5'h05;
  localparam logic [4:0] OP_SOFT_SEQ_RESET = 5'h06;
  localparam logic [4:0] OP_CTRL_WRITE = 5'h07;
  localparam logic [4:0] OP_CTRL_READ = 5'h08;
  localparam logic [4:0] OP_MEM_WINDOW = 5'h09;
  localparam logic [4:0] OP_MEM_AUTOINC_READ = 5'h0A;
  localparam logic [4:0] OP_TABLE_CMD = 5'h0B;
  localparam logic [4:0] OP_CMP_READ = 5'h0C;
  localparam logic [4:0] OP_ENTER_ID = 5'h0D;
  localparam logic [4:0] OP_ID_REG_ACCESS = 5'h0E;
  localparam logic [4:0] OP_NEXT_PRIORITY = 5'h0F;
  localparam logic [4:0] OP_LEAVE_ID = 5'h10;
  localparam logic [4:0] OP_ENTER_CONFIG = 5'h11;
  localparam logic [4:0] OP_ADDR_REG_ACCESS = 5'h12;
  localparam logic [4:0] OP_LEAVE_CONFIG = 5'h13;
  localparam logic [4:0] OP_OTHER_REG = 5'h14;
  // ==========================================
  // pointer geometry
  localparam int SEQ_STEPS = 8;
  localparam logic [2:0] SEQ_END_DEFAULT = 3'h7;
  // ==========================================
  // modes, gray along host->standby->input/output
  typedef enum logic [2:0] {
    PMA_HOST = 3'b000,
    PMA_STANDBY = 3'b001,
    PMA_INPUT = 3'b011,
    PMA_OUTPUT = 3'b101,
    PMA_ID_SUB = 3'b100,
    PMA_CFG_SUB = 3'b010
  } pma_mode_e;
endpackage

// ---- include/pma_seq_if.sv ----
`timescale 1ns/10ps
// Purpose: carries one sequence pointer's controls and status
// Assumes: single clock domain
// Notes: step and clear are one-cycle pulses
interface pma_seq_if;
  logic step;
  logic clear;
  logic [2:0] end_step;
  logic [2:0] ptr;
  logic halted;
  modport ctl (output step, output clear, output end_step, input ptr, input halted);
  modport seq (input step, input clear, input end_step, output ptr, output halted);
endinterface

// ---- verilog/pma_seq_ptr.sv ----
`timescale 1ns/10ps
// Purpose: one sequence pointer that steps and halts at its end step
// Assumes: step and clear from the same clock domain
// Notes: clear wins over step so a reset always restarts cleanly
module pma_seq_ptr (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  pma_seq_if.seq sq
);
  // ==========================================
  // pointer
  logic [2:0] ptr;
  logic halted;
  wire at_end = (ptr == sq.end_step);
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ptr <= 3'h0;
      halted <= 1'b0;
    end else if (i_ce) begin
      if (sq.clear) begin
        ptr <= 3'h0;
        halted <= 1'b0;
      end else if (sq.step && !halted) begin
        if (at_end) begin
          halted <= 1'b1;
        end else begin
          ptr <= ptr + 3'h1;
        end
      end
    end
  end
  assign sq.ptr = ptr;
  assign sq.halted = halted;
endmodule

// ---- verilog/pma_arbiter.sv ----
`timescale 1ns/10ps
// Purpose: operation-mode controller for internal port arbitration
// Assumes: pins pass a two-flop synchroniser; host ops are same-clock strobes
// Notes: ports strobes are sampled as assertion edges of the synchronised level (rising for write, falling for read)
module pma_arbiter (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_reset_pin_n,
  input wire logic i_seq_reset_pin_n,
  input wire logic i_arbitration_select_pin,
  input wire logic i_wr_strobe,
  input wire logic i_rd_strobe_n,
  input wire logic i_host_valid,
  input wire logic [4:0] i_host_op,
  input wire logic [2:0] i_in_end_step,
  input wire logic [2:0] i_out_end_step,
  output logic o_host_accept,
  output logic o_host_reject,
  output logic o_in_step,
  output logic o_out_step,
  output logic [2:0] o_in_ptr,
  output logic [2:0] o_out_ptr,
  output logic [2:0] o_mode,
  output logic o_input_busy_pin,
  output logic o_output_busy_pin
);
  // ==========================================
  // pin synchronisers, first stage read only by second
  logic [1:0] rst_s1, rst_s2, sq_s1, sq_s2, sel_s1, sel_s2, wr_s1, wr_s2, rd_s1, rd_s2;
  logic wr_d, rd_d, rstp_d, sqp_d;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rst_s1 <= 2'h3;
      sq_s1 <= 2'h3;
      sel_s1 <= 2'h0;
      wr_s1 <= 2'h0;
      rd_s1 <= 2'h3;
    end else if (i_ce) begin
      rst_s1 <= {rst_s1[0], i_reset_pin_n};
      sq_s1 <= {sq_s1[0], i_seq_reset_pin_n};
      sel_s1 <= {sel_s1[0], i_arbitration_select_pin};
      wr_s1 <= {wr_s1[0], i_wr_strobe};
      rd_s1 <= {rd_s1[0], i_rd_strobe_n};
    end
  end
  assign rst_s2 = rst_s1;
  assign sq_s2 = sq_s1;
  assign sel_s2 = sel_s1;
  assign wr_s2 = wr_s1;
  assign rd_s2 = rd_s1;
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      wr_d <= 1'b0;
      rd_d <= 1'b1;
      rstp_d <= 1'b1;
      sqp_d <= 1'b1;
    end else if (i_ce) begin
      wr_d <= wr_s2[1];
      rd_d <= rd_s2[1];
      rstp_d <= rst_s2[1];
      sqp_d <= sq_s2[1];
    end
  end
  wire wr_edge = wr_s2[1] & ~wr_d;
  wire rd_edge = ~rd_s2[1] & rd_d;
  wire rst_pulse = ~rst_s2[1] & rstp_d;
  wire sq_pulse = ~sq_s2[1] & sqp_d;
  wire external = sel_s2[1];
  // ==========================================
  // mode state and decode
  pma_pkg::pma_mode_e mode, next_mode;
  logic pend_seq_end, pend_imm, next_pend_seq_end, next_pend_imm;
  wire in_host = (mode == pma_pkg::PMA_HOST);
  wire in_id = (mode == pma_pkg::PMA_ID_SUB);
  wire in_cfg = (mode == pma_pkg::PMA_CFG_SUB);
  wire in_stby = (mode == pma_pkg::PMA_STANDBY);
  wire in_inp = (mode == pma_pkg::PMA_INPUT);
  wire in_outp = (mode == pma_pkg::PMA_OUTPUT);
  wire in_seq = in_inp | in_outp;
  wire op_v = i_host_valid;
  wire [4:0] op = i_host_op;
  function automatic logic is_op(input logic [4:0] a, input logic [4:0] b);
    is_op = (a == b);
  endfunction
  wire op_soft_rst = op_v & is_op(op, pma_pkg::OP_SOFT_RESET);
  wire op_host = op_v & is_op(op, pma_pkg::OP_TO_HOST);
  wire op_imm = op_v & is_op(op, pma_pkg::OP_TO_HOST_IMM);
  wire op_sqe = op_v & is_op(op, pma_pkg::OP_TO_HOST_SEQ_END);
  wire op_stby = op_v & is_op(op, pma_pkg::OP_TO_STANDBY);
  wire op_seq_reset_pin = op_v & is_op(op, pma_pkg::OP_SOFT_SEQ_RESET);
  wire op_id_in = op_v & is_op(op, pma_pkg::OP_ENTER_ID);
  wire op_id_out = op_v & is_op(op, pma_pkg::OP_LEAVE_ID);
  wire op_cf_in = op_v & is_op(op, pma_pkg::OP_ENTER_CONFIG);
  wire op_cf_out = op_v & is_op(op, pma_pkg::OP_LEAVE_CONFIG);
  // operations that touch the table or its guarded registers, plus standby and submode entry
  wire host_only = is_op(op, pma_pkg::OP_CTRL_WRITE) |
    is_op(op, pma_pkg::OP_MEM_WINDOW) | is_op(op, pma_pkg::OP_MEM_AUTOINC_READ) |
    is_op(op, pma_pkg::OP_TABLE_CMD) |
    is_op(op, pma_pkg::OP_CMP_READ) |
    op_id_in | op_cf_in | op_stby;
  wire id_ok = is_op(op, pma_pkg::OP_ENTER_ID) | is_op(op, pma_pkg::OP_ID_REG_ACCESS) |
    is_op(op, pma_pkg::OP_NEXT_PRIORITY) | is_op(op, pma_pkg::OP_LEAVE_ID);
  wire cfg_ok = is_op(op, pma_pkg::OP_ENTER_CONFIG) |
    is_op(op, pma_pkg::OP_ADDR_REG_ACCESS) | is_op(op, pma_pkg::OP_MEM_WINDOW) |
    is_op(op, pma_pkg::OP_LEAVE_CONFIG);
  wire sub_only = is_op(op, pma_pkg::OP_ID_REG_ACCESS) | is_op(op, pma_pkg::OP_NEXT_PRIORITY) |
    is_op(op, pma_pkg::OP_ADDR_REG_ACCESS) | op_id_out | op_cf_out;
  // soft reset is always honoured; submodes bind in both arbitration styles
  wire accept = op_v & (op_soft_rst |
    (in_id ? id_ok : in_cfg ? cfg_ok :
     sub_only ? 1'b0 :
     external ? 1'b1 :
     (in_host | ~host_only)));
  // ==========================================
  // sequence pointers
  pma_seq_if in_if();
  pma_seq_if out_if();
  wire seq_clear = (sq_pulse | (accept & op_seq_reset_pin));
  wire in_take = wr_edge & ~in_if.halted & (external | in_stby | in_inp);
  wire out_take = rd_edge & ~out_if.halted & (external | in_stby | in_outp);
  wire in_last = in_take & (in_if.ptr == i_in_end_step);
  wire out_last = out_take & (out_if.ptr == i_out_end_step);
  assign in_if.step = in_take & ~seq_clear;
  assign in_if.clear = seq_clear;
  assign in_if.end_step = i_in_end_step;
  assign out_if.step = out_take & ~seq_clear;
  assign out_if.clear = seq_clear;
  assign out_if.end_step = i_out_end_step;
  pma_seq_ptr u_in_ptr (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .sq(in_if)
  );
  pma_seq_ptr u_out_ptr (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .sq(out_if)
  );
  // ==========================================
  // next-mode logic
  always_comb begin
    next_mode = mode;
    next_pend_seq_end = pend_seq_end;
    next_pend_imm = pend_imm;
    if (rst_pulse | (accept & op_soft_rst)) begin
      next_mode = pma_pkg::PMA_HOST;
      next_pend_seq_end = 1'b0;
      next_pend_imm = 1'b0;
    end else begin
      unique case (mode)
        pma_pkg::PMA_HOST: begin
          if (accept & op_stby) begin
            next_mode = pma_pkg::PMA_STANDBY;
          end else if (accept & op_id_in) begin
            next_mode = pma_pkg::PMA_ID_SUB;
          end else if (accept & op_cf_in) begin
            next_mode = pma_pkg::PMA_CFG_SUB;
          end
        end
        pma_pkg::PMA_ID_SUB: begin
          if (accept & op_id_out) begin
            next_mode = pma_pkg::PMA_HOST;
          end
        end
        pma_pkg::PMA_CFG_SUB: begin
          if (accept & op_cf_out) begin
            next_mode = pma_pkg::PMA_HOST;
          end
        end
        pma_pkg::PMA_STANDBY: begin
          if (accept & (op_host | op_imm)) begin
            next_mode = pma_pkg::PMA_HOST;
            next_pend_seq_end = 1'b0;
          end else if (accept & op_sqe) begin
            next_pend_seq_end = 1'b1;
          end else if (~external & in_take) begin
            next_mode = in_last ? pma_pkg::PMA_STANDBY : pma_pkg::PMA_INPUT;
          end else if (~external & out_take) begin
            next_mode = out_last ? pma_pkg::PMA_STANDBY : pma_pkg::PMA_OUTPUT;
          end
        end
        default: begin
          // input or output sequence
          if (seq_clear) begin
            next_mode = pma_pkg::PMA_STANDBY;
          end else if ((in_inp & in_take) | (in_outp & out_take)) begin
            if (pend_imm | (accept & op_imm)) begin
              next_mode = pma_pkg::PMA_HOST;
              next_pend_imm = 1'b0;
              next_pend_seq_end = 1'b0;
            end else if ((in_inp & in_last) | (in_outp & out_last)) begin
              next_mode = (pend_seq_end | (accept & (op_host | op_sqe))) ?
                pma_pkg::PMA_HOST : pma_pkg::PMA_STANDBY;
              next_pend_seq_end = 1'b0;
            end
          end else if (accept & op_imm) begin
            next_pend_imm = 1'b1;
          end else if (accept & (op_host | op_sqe)) begin
            next_pend_seq_end = 1'b1;
          end
        end
      endcase
    end
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      mode <= pma_pkg::PMA_HOST;
      pend_seq_end <= 1'b0;
      pend_imm <= 1'b0;
    end else if (i_ce) begin
      mode <= next_mode;
      pend_seq_end <= next_pend_seq_end;
      pend_imm <= next_pend_imm;
    end
  end
  // ==========================================
  // registered outputs
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_host_accept <= 1'b0;
      o_host_reject <= 1'b0;
      o_in_step <= 1'b0;
      o_out_step <= 1'b0;
      o_in_ptr <= 3'h0;
      o_out_ptr <= 3'h0;
      o_mode <= 3'h0;
      o_input_busy_pin <= 1'b0;
      o_output_busy_pin <= 1'b0;
    end else if (i_ce) begin
      o_host_accept <= accept;
      o_host_reject <= op_v & ~accept;
      o_in_step <= in_if.step;
      o_out_step <= out_if.step;
      o_in_ptr <= in_if.ptr;
      o_out_ptr <= out_if.ptr;
      o_mode <= next_mode;
      // busy pins follow the mode being entered
      o_input_busy_pin <= (next_mode == pma_pkg::PMA_INPUT) |
        (next_mode == pma_pkg::PMA_STANDBY);
      o_output_busy_pin <= (next_mode == pma_pkg::PMA_OUTPUT) |
        (next_mode == pma_pkg::PMA_STANDBY);
    end
  end
endmodule

// ---- bench/pma_arbiter_properties.sv ----
`timescale 1ns/10ps
// Purpose: timing properties of the port-mode arbiter
// Assumes: one clock, asynchronous active-high reset
// Notes: pointers may lag a step by a cycle, so they are read one cycle on
module pma_arbiter_properties (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_arbitration_select_pin,
  input wire logic i_host_valid,
  input wire logic [4:0] i_host_op,
  input wire logic [2:0] i_in_end_step,
  input wire logic o_host_accept,
  input wire logic o_host_reject,
  input wire logic o_in_step,
  input wire logic o_out_step,
  input wire logic [2:0] o_in_ptr,
  input wire logic [2:0] o_mode,
  input wire logic o_input_busy_pin,
  input wire logic o_output_busy_pin
);
  // ==========================================
  // properties
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  wire ia = !i_arbitration_select_pin;
  wire [1:0] busy = {o_input_busy_pin, o_output_busy_pin};
  sequence s_op(logic [4:0] c);
    ia && i_host_valid && i_host_op == c;
  endsequence
  sequence s_in_step(logic at_end);
    o_in_step && (($past(o_in_ptr) == i_in_end_step) == at_end);
  endsequence
  property p_busy_host;
    ia && o_mode inside {pma_pkg::PMA_HOST, pma_pkg::PMA_ID_SUB, pma_pkg::PMA_CFG_SUB}
      |-> busy == 2'h0;
  endproperty
  a_busy_host: assert property (p_busy_host) else $error("busy pins set in host");
  property p_busy_idle; ia && o_mode == pma_pkg::PMA_STANDBY |-> busy == 2'h3; endproperty
  a_busy_idle: assert property (p_busy_idle) else $error("busy pins wrong in standby");
  property p_host_quiet;
    ia && o_mode == pma_pkg::PMA_HOST && $past(o_mode) == pma_pkg::PMA_HOST
      |-> !o_in_step && !o_out_step;
  endproperty
  a_host_quiet: assert property (p_host_quiet) else $error("port step in host");
  property p_in_adv; s_in_step(1'b0) |=> o_in_ptr == $past(o_in_ptr, 2) + 3'h1; endproperty
  a_in_adv: assert property (p_in_adv) else $error("input pointer did not advance");
  property p_in_end;
    s_in_step(1'b1) |=> o_in_ptr == $past(o_in_ptr, 2) && o_mode != pma_pkg::PMA_INPUT;
  endproperty
  a_in_end: assert property (p_in_end) else $error("input pointer ran past end");
  property p_start_in;
    ia && o_in_step && $past(o_mode) == pma_pkg::PMA_STANDBY |-> o_mode == pma_pkg::PMA_INPUT;
  endproperty
  a_start_in: assert property (p_start_in) else $error("no input mode entry");
  property p_ctrl_wr;
    s_op(pma_pkg::OP_CTRL_WRITE) ##0 o_mode == pma_pkg::PMA_STANDBY |=> o_host_reject;
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write taken in standby");
  property p_to_standby;
    s_op(pma_pkg::OP_TO_STANDBY) ##0 o_mode == pma_pkg::PMA_HOST
      |=> o_host_accept && o_mode == pma_pkg::PMA_STANDBY;
  endproperty
  a_to_standby: assert property (p_to_standby) else $error("standby command failed");
  property p_soft_reset;
    s_op(pma_pkg::OP_SOFT_RESET) |=> o_host_accept && o_mode == pma_pkg::PMA_HOST;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset not to host");
  property p_seq_rst_in;
    s_op(pma_pkg::OP_SOFT_SEQ_RESET) ##0 o_mode == pma_pkg::PMA_INPUT
      |=> o_mode == pma_pkg::PMA_STANDBY;
  endproperty
  a_seq_rst_in: assert property (p_seq_rst_in) else $error("sequence reset kept input");
endmodule
bind pma_arbiter pma_arbiter_properties u_pma_arbiter_properties (.i_mclk(i_mclk),
  .i_rst(i_rst), .i_arbitration_select_pin(i_arbitration_select_pin),
  .i_host_valid(i_host_valid), .i_host_op(i_host_op), .i_in_end_step(i_in_end_step),
  .o_host_accept(o_host_accept), .o_host_reject(o_host_reject), .o_in_step(o_in_step),
  .o_out_step(o_out_step), .o_in_ptr(o_in_ptr), .o_mode(o_mode),
  .o_input_busy_pin(o_input_busy_pin), .o_output_busy_pin(o_output_busy_pin));

// ---- bench/pma_port_src.sv ----
`timescale 1ns/10ps
// Purpose: input stream source and result reader at the two ports
// Assumes: strobes are launched just after a clock edge
// Notes: strobes are held three cycles so the two-flop sync cannot miss them
module pma_port_src (
  input wire logic i_mclk,
  output logic o_wr_strobe,
  output logic o_rd_strobe_n
);
  initial begin
    o_wr_strobe = 1'b0;
    o_rd_strobe_n = 1'b1;
  end
  task automatic pulse(input logic rd);
    @(posedge i_mclk);
    if (rd) o_rd_strobe_n <= 1'b0;
    else o_wr_strobe <= 1'b1;
    repeat (3) @(posedge i_mclk);
    o_rd_strobe_n <= 1'b1;
    o_wr_strobe <= 1'b0;
    repeat (4) @(posedge i_mclk);
  endtask
endmodule

// ---- bench/tb_pma_arbiter.sv ----
`timescale 1ns/10ps
// Purpose: directed bench for the port-mode arbiter
// Assumes: internal arbitration until t_external, end steps 3 (input) and 2 (output)
// Notes: state is read two cycles after an action since pointers lag
module tb_pma_arbiter;
  logic clk, rst, rpn, spn, hv, wr, rdn, acc, rej, ib, ob, sel;
  logic [4:0] hc;
  logic [2:0] md, ip, opt;
  int mismatches, tests_run;
  pma_arbiter u_pma_arbiter (.i_mclk(clk), .i_rst(rst), .i_ce(1'b1), .i_reset_pin_n(rpn),
    .i_seq_reset_pin_n(spn), .i_arbitration_select_pin(sel), .i_wr_strobe(wr),
    .i_rd_strobe_n(rdn), .i_host_valid(hv), .i_host_op(hc), .i_in_end_step(3'h3),
    .i_out_end_step(3'h2), .o_host_accept(acc), .o_host_reject(rej), .o_in_step(),
    .o_out_step(), .o_in_ptr(ip), .o_out_ptr(opt), .o_mode(md), .o_input_busy_pin(ib),
    .o_output_busy_pin(ob));
  pma_port_src u_pma_port_src (.i_mclk(clk), .o_wr_strobe(wr), .o_rd_strobe_n(rdn));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================
  // helpers
  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic ho(input logic [4:0] c, input logic ok);
    @(posedge clk);
    hv <= 1'b1;
    hc <= c;
    @(posedge clk);
    hv <= 1'b0;
    #1;
    chk({1'b0, acc, rej}, {1'b0, ok, !ok});
  endtask
  task automatic st(input logic [2:0] m, input logic [1:0] b, input logic [2:0] p, q);
    repeat (2) @(posedge clk);
    #1;
    chk(md, m);
    chk({1'b0, ib, ob}, {1'b0, b});
    chk(ip, p);
    chk(opt, q);
  endtask
  task automatic sb(input logic rd);
    u_pma_port_src.pulse(rd);
  endtask
  task automatic pin(input logic sq);
    @(posedge clk);
    if (sq) spn <= 1'b0;
    else rpn <= 1'b0;
    repeat (2) @(posedge clk);
    spn <= 1'b1;
    rpn <= 1'b1;
    repeat (5) @(posedge clk);
  endtask
  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_host;
    st(pma_pkg::PMA_HOST, 2'h0, 3'h0, 3'h0);
    sb(1'b0);
    sb(1'b1);
    st(pma_pkg::PMA_HOST, 2'h0, 3'h0, 3'h0);
  endtask
  task automatic t_sub;
    ho(pma_pkg::OP_ENTER_ID, 1'b1);
    st(pma_pkg::PMA_ID_SUB, 2'h0, 3'h0, 3'h0);
    ho(pma_pkg::OP_CTRL_WRITE, 1'b0);
    ho(pma_pkg::OP_ID_REG_ACCESS, 1'b1);
    ho(pma_pkg::OP_NEXT_PRIORITY, 1'b1);
    ho(pma_pkg::OP_LEAVE_ID, 1'b1);
    ho(pma_pkg::OP_ENTER_CONFIG, 1'b1);
    ho(pma_pkg::OP_TABLE_CMD, 1'b0);
    ho(pma_pkg::OP_ADDR_REG_ACCESS, 1'b1);
    ho(pma_pkg::OP_MEM_WINDOW, 1'b1);
    ho(pma_pkg::OP_LEAVE_CONFIG, 1'b1);
  endtask
  task automatic t_standby;
    ho(pma_pkg::OP_SOFT_SEQ_RESET, 1'b1);
    ho(pma_pkg::OP_TO_STANDBY, 1'b1);
    st(pma_pkg::PMA_STANDBY, 2'h3, 3'h0, 3'h0);
    ho(pma_pkg::OP_CTRL_WRITE, 1'b0);
    ho(pma_pkg::OP_CTRL_READ, 1'b1);
    ho(pma_pkg::OP_MEM_WINDOW, 1'b0);
    ho(pma_pkg::OP_MEM_AUTOINC_READ, 1'b0);
    ho(pma_pkg::OP_TABLE_CMD, 1'b0);
    ho(pma_pkg::OP_CMP_READ, 1'b0);
    st(pma_pkg::PMA_STANDBY, 2'h3, 3'h0, 3'h0);
  endtask
  task automatic t_input;
    sb(1'b0);
    st(pma_pkg::PMA_INPUT, 2'h2, 3'h1, 3'h0);
    sb(1'b1);
    ho(pma_pkg::OP_TABLE_CMD, 1'b0);
    st(pma_pkg::PMA_INPUT, 2'h2, 3'h1, 3'h0);
    ho(pma_pkg::OP_SOFT_SEQ_RESET, 1'b1);
    st(pma_pkg::PMA_STANDBY, 2'h3, 3'h0, 3'h0);
    repeat (4) sb(1'b0);
    st(pma_pkg::PMA_STANDBY, 2'h3, 3'h3, 3'h0);
    sb(1'b0);
    st(pma_pkg::PMA_STANDBY, 2'h3, 3'h3, 3'h0);
  endtask
  task automatic t_output;
    pin(1'b1);
    st(pma_pkg::PMA_STANDBY, 2'h3, 3'h0, 3'h0);
    sb(1'b1);
    st(pma_pkg::PMA_OUTPUT, 2'h1, 3'h0, 3'h1);
    sb(1'b0);
    ho(pma_pkg::OP_CMP_READ, 1'b0);
    st(pma_pkg::PMA_OUTPUT, 2'h1, 3'h0, 3'h1);
    repeat (2) sb(1'b1);
    st(pma_pkg::PMA_STANDBY, 2'h3, 3'h0, 3'h2);
    sb(1'b1);
    st(pma_pkg::PMA_STANDBY, 2'h3, 3'h0, 3'h2);
  endtask
  task automatic t_to_host;
    ho(pma_pkg::OP_TO_HOST, 1'b1);
    st(pma_pkg::PMA_HOST, 2'h0, 3'h0, 3'h2);
    ho(pma_pkg::OP_SOFT_SEQ_RESET, 1'b1);
    ho(pma_pkg::OP_TO_STANDBY, 1'b1);
    sb(1'b0);
    ho(pma_pkg::OP_TO_HOST_IMM, 1'b1);
    sb(1'b0);
    st(pma_pkg::PMA_HOST, 2'h0, 3'h2, 3'h0);
    ho(pma_pkg::OP_SOFT_RESET, 1'b1);
    ho(pma_pkg::OP_TO_STANDBY, 1'b1);
    pin(1'b0);
    chk(md, pma_pkg::PMA_HOST);
  endtask
  task automatic t_external;
    ho(pma_pkg::OP_SOFT_SEQ_RESET, 1'b1);
    ho(pma_pkg::OP_TO_STANDBY, 1'b1);
    ho(pma_pkg::OP_TO_HOST_SEQ_END, 1'b1);
    st(pma_pkg::PMA_STANDBY, 2'h3, 3'h0, 3'h0);
    repeat (4) sb(1'b0);
    st(pma_pkg::PMA_HOST, 2'h0, 3'h3, 3'h0);
    // external arbitration: only the submode limits remain
    @(posedge clk);
    sel <= 1'b1;
    repeat (4) @(posedge clk);
    ho(pma_pkg::OP_SOFT_SEQ_RESET, 1'b1);
    sb(1'b0);
    st(pma_pkg::PMA_HOST, 2'h0, 3'h1, 3'h0);
    ho(pma_pkg::OP_ADDR_REG_ACCESS, 1'b0);
  endtask
  // ==========================================
  // main sequence; the watchdog cuts a hang short
  initial begin
    rst = 1'b1;
    rpn = 1'b1;
    spn = 1'b1;
    hv = 1'b0;
    sel = 1'b0;
    hc = 5'h00;
    mismatches = 0;
    tests_run = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_host;
    t_sub;
    t_standby;
    t_input;
    t_output;
    t_to_host;
    t_external;
    summarize;
  end
  initial begin
    #100000;
    mismatches++;
    summarize;
  end
endmodule
